// ==== vga_tgs_pkg.sv ====
// Purpose: Shared constants and types of the gain time sequencer.
// Assumes: 24-bit serial frames, 8-bit address then 16-bit data.
// Notes: Gain is held in 0.125 dB units, 0 meaning -5 dB.
package vga_tgs_pkg;
   localparam int SAMP_DIV = 2;
   localparam int FRAME_BITS = 24;
   localparam logic [4:0] LAST_BIT = 5'h17;
   localparam logic [4:0] ADDR_LAST_BIT = 5'h07;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_TAB_LO = 8'h01;
   localparam logic [7:0] A_TAB_HI = 8'h94;
   localparam logic [7:0] A_START_IDX = 8'h95;
   localparam logic [7:0] A_STOP_IDX = 8'h96;
   localparam logic [7:0] A_START_GAIN = 8'h97;
   localparam logic [7:0] A_HOLD = 8'h98;
   localparam logic [7:0] A_MODE = 8'h99;
   localparam logic [7:0] A_COARSE = 8'h9A;
   localparam logic [7:0] A_SLOPE = 8'h9B;
   localparam logic [7:0] A_STATUS = 8'h9C;
   localparam int TAB_DEPTH = 148;
   localparam int CTRL_BANK_BIT = 2;
   localparam int CTRL_READ_BIT = 1;
   localparam int SMOOTH_BIT = 7;
   localparam int SOFT_SYNC_BIT = 5;
   localparam int UNIFORM_BIT = 4;
   localparam int FIXED_BIT = 3;
   localparam int DIR_BIT = 8;
   localparam logic [5:0] COARSE_MAX = 6'h24;
   localparam logic [8:0] GAIN_MAX = 9'h127;
   localparam logic [2:0] SUB_LAST = 3'h7;
   localparam logic [3:0] FINE_STEP = 4'h1;
   localparam logic [3:0] COARSE_STEP = 4'h8;
   localparam int HOLD_PER_CODE = 33;
   typedef struct packed {
      logic [7:0] start_idx;
      logic [7:0] stop_idx;
      logic substep_smoothing_on;
      logic [5:0] start_gain;
      logic [7:0] hold;
      logic soft_sync;
      logic uniform;
      logic fixed_level_select;
      logic [2:0] fractional_gain_offset;
      logic [5:0] coarse;
      logic [7:0] slope;
   } cfg_t;
   localparam cfg_t CFG_RESET = '0;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RAMP = 2'b01,
      ST_HOLD = 2'b10,
      ST_RETURN = 2'b11
   } eng_state_t;
endpackage : vga_tgs_pkg

// ==== vga_gain_time_sequencer.sv ====
// Purpose: Per-sample gain engine for the eight receive amplifiers.
// Assumes: ref_clk is the device input clock; serial pins are async.
// Notes: Registers are reached only through the serial port.
// How it works
// - Curve, uniform and fixed modes decide how gain is produced.
// - Applied gain changes only on the sampling enable.
// - 148 nine-bit table entries written at 1..148 with bank bit set.
// - Entry top bit picks direction; low byte times 8 sets dwell per dB.
// - Smoothing off: whole dB steps; on: eight 0.125 dB sub-steps.
// - Only entries from first to last pointer are stepped.
// - Sync pulse outside fixed mode loads start gain and starts stepping at once.
// - Stop at last pointer or range limit, then hold the gain.
// - After hold, return 1 dB per sample to start gain, then idle.
// - Sync is sampled on sampling clock edges; host aligns it.
// - Soft sync bit reruns the whole sequence until cleared.
// - Soft sync starts at the first sampling edge after the completing serial write.
// - Curve ends at start+diff-2*decrements, plus or minus 0.875 dB smoothed, as the last entry's direction bit picks.
// - Uniform mode ramps by slope register, ignoring the table.
// - Uniform slope counts samples per 0.125 dB or 8s per dB.
// - Uniform end gain is start plus pointer difference, +0.875 dB smoothed.
// - Uniform ramps only rise; fall only when returning.
// - Fixed mode applies coarse plus fine gain constantly.
// - Coarse code is -5 dB plus code, saturating at 0x24.
// - Fine code adds code times 0.125 dB.
// - Start gain decodes as -5 dB plus code, also saturating at 0x24.
// - Hold lasts 33 samples per hold code unit.
// - Bank bit selects curve bank; register zero always reachable.
// - Sampling clock is the input clock divided by two.
`timescale 1ns/1ps
module vga_gain_time_sequencer
   import vga_tgs_pkg::*;
#(
   parameter int HOLD_MULT = HOLD_PER_CODE
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic sync_in,
   input wire logic ser_clk,
   input wire logic ser_en_n,
   input wire logic ser_data,
   output logic ser_dout,
   output logic [8:0] gain_code,
   output logic curve_active
);

   // Code to 0.125 dB units, saturating at 0x24
   function automatic logic [8:0] to_units(input logic [5:0] c);
      logic [5:0] s;
      s = (c > COARSE_MAX) ? COARSE_MAX : c;
      return {s, 3'b000};
   endfunction : to_units

   logic rst_meta_r;
   logic rst_sync_r;
   logic rst_n;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   assign rst_n = rst_sync_r;

   // Pin synchronisers; stage two feeds logic, serial clock edges also use stage three
   logic [1:0] sync_s_r;
   logic [2:0] sclk_s_r;
   logic [1:0] sen_s_r;
   logic [1:0] sdat_s_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_s_r <= 2'b00;
         sclk_s_r <= 3'b000;
         sen_s_r <= 2'b11;
         sdat_s_r <= 2'b00;
      end else begin
         sync_s_r <= {sync_s_r[0], sync_in};
         sclk_s_r <= {sclk_s_r[1:0], ser_clk};
         sen_s_r <= {sen_s_r[0], ser_en_n};
         sdat_s_r <= {sdat_s_r[0], ser_data};
      end
   end

   logic samp_en_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) samp_en_r <= 1'b0;
      else samp_en_r <= ~samp_en_r;
   end

   // Serial register port
   logic [23:0] shift_r;
   logic [4:0] bit_cnt_r;
   logic [15:0] rd_sh_r;
   logic bank_r;
   logic readout_r;
   cfg_t cfg_r;
   // Engine state is declared here because the readback mux reads it
   eng_state_t eng_q_r;
   logic [8:0] gain_r;
   logic [8:0] tab [1:TAB_DEPTH];
   logic sclk_rise;
   logic sclk_fall;
   logic [23:0] word_w;
   logic frame_done;
   logic addr_done;
   logic [7:0] wr_addr;
   logic [15:0] wr_data;
   logic wr_ok;
   logic tab_hit;
   logic cfg_wr;
   logic soft_rise;
   assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2] & ~sen_s_r[1];
   assign sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
   assign word_w = {shift_r[22:0], sdat_s_r[1]};
   assign frame_done = sclk_rise && (bit_cnt_r == LAST_BIT);
   assign addr_done = sclk_rise && (bit_cnt_r == ADDR_LAST_BIT);
   assign wr_addr = word_w[23:16];
   assign wr_data = word_w[15:0];
   assign wr_ok = frame_done && !readout_r;
   assign tab_hit = bank_r && wr_addr >= A_TAB_LO
                    && wr_addr <= A_TAB_HI;
   assign cfg_wr = wr_ok && bank_r;
   assign soft_rise = cfg_wr && wr_addr == A_MODE
                      && wr_data[SOFT_SYNC_BIT]
                      && !cfg_r.soft_sync;

   // Readback; smoothing bit reads inverted as on the real part
   function automatic logic [15:0] rd_mux(input logic [7:0] a);
      logic [15:0] v;
      v = '0;
      if (a == A_CTRL) v = {13'h0000, bank_r, readout_r, 1'b0};
      else if (bank_r && a >= A_TAB_LO && a <= A_TAB_HI)
         v = {7'h00, tab[a]};
      else if (bank_r) begin
         unique case (a)
            A_START_IDX: v = {8'h00, cfg_r.start_idx};
            A_STOP_IDX: v = {8'h00, cfg_r.stop_idx};
            A_START_GAIN: v = {8'h00, ~cfg_r.substep_smoothing_on,
                               1'b0, cfg_r.start_gain};
            A_HOLD: v = {8'h00, cfg_r.hold};
            A_MODE: v = {10'h000, cfg_r.soft_sync, cfg_r.uniform,
                         cfg_r.fixed_level_select,
                         cfg_r.fractional_gain_offset};
            A_COARSE: v = {10'h000, cfg_r.coarse};
            A_SLOPE: v = {8'h00, cfg_r.slope};
            A_STATUS: v = {5'h00, eng_q_r, gain_r};
            default: v = '0;
         endcase
      end
      return v;
   endfunction : rd_mux

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_r <= '0;
         bit_cnt_r <= '0;
         rd_sh_r <= '0;
         ser_dout <= 1'b0;
      end else begin
         if (sen_s_r[1]) bit_cnt_r <= '0;
         else if (sclk_rise) begin
            shift_r <= word_w;
            bit_cnt_r <= frame_done ? 5'h00 : bit_cnt_r + 5'h01;
         end
         if (addr_done) rd_sh_r <= rd_mux(word_w[7:0]);
         else if (sclk_rise) rd_sh_r <= {rd_sh_r[14:0], 1'b0};
         if (sclk_fall) ser_dout <= readout_r & rd_sh_r[15];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bank_r <= 1'b0;
         readout_r <= 1'b0;
      end else if (frame_done && wr_addr == A_CTRL) begin
         bank_r <= wr_data[CTRL_BANK_BIT];
         readout_r <= wr_data[CTRL_READ_BIT];
      end
   end

   // Table is plain storage with no reset
   always_ff @(posedge ref_clk) begin
      if (wr_ok && tab_hit) tab[wr_addr] <= wr_data[8:0];
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) cfg_r <= CFG_RESET;
      else if (cfg_wr) begin
         unique case (wr_addr)
            A_START_IDX: cfg_r.start_idx <= wr_data[7:0];
            A_STOP_IDX: cfg_r.stop_idx <= wr_data[7:0];
            A_START_GAIN: begin
               cfg_r.substep_smoothing_on <= wr_data[SMOOTH_BIT];
               cfg_r.start_gain <= wr_data[5:0];
            end
            A_HOLD: cfg_r.hold <= wr_data[7:0];
            A_MODE: begin
               cfg_r.soft_sync <= wr_data[SOFT_SYNC_BIT];
               cfg_r.uniform <= wr_data[UNIFORM_BIT];
               cfg_r.fixed_level_select <= wr_data[FIXED_BIT];
               cfg_r.fractional_gain_offset <= wr_data[2:0];
            end
            A_COARSE: cfg_r.coarse <= wr_data[5:0];
            A_SLOPE: cfg_r.slope <= wr_data[7:0];
            default: cfg_r <= cfg_r;
         endcase
      end
   end

   // Start requests wait for the next sampling edge
   logic soft_go_r;
   logic sync_prev_r;
   logic pin_go;
   assign pin_go = samp_en_r && sync_s_r[1] && !sync_prev_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_go_r <= 1'b0;
         sync_prev_r <= 1'b0;
      end else begin
         if (samp_en_r) sync_prev_r <= sync_s_r[1];
         if (soft_rise) soft_go_r <= 1'b1; // Set beats clear
         else if (samp_en_r) soft_go_r <= 1'b0;
      end
   end

   // Gain engine
   logic [7:0] idx_r;
   logic [2:0] sub_r;
   logic [7:0] dwell_r;
   logic [13:0] hold_r;
   logic [8:0] entry;
   logic [7:0] code_w;
   logic dec_w;
   logic [7:0] per_w;
   logic last_w;
   logic sub_end;
   logic [3:0] step_w;
   logic [9:0] up_w;
   logic bad_w;
   logic [8:0] start_u;
   logic [8:0] fixed_u;
   logic [13:0] hold_load;
   logic go;
   logic [8:0] ret_up;
   logic [8:0] ret_dn;

   assign entry = (idx_r >= A_TAB_LO && idx_r <= A_TAB_HI)
                  ? tab[idx_r] : 9'h000;
   assign code_w = cfg_r.uniform ? cfg_r.slope
                   : entry[7:0];
   assign dec_w = !cfg_r.uniform && entry[DIR_BIT];
   assign per_w = (code_w == 8'h00) ? 8'h01 : code_w;
   assign last_w = idx_r >= cfg_r.stop_idx;
   assign sub_end = dwell_r == per_w - 8'h01;
   // Final entry: 7 fine steps smoothed, none unsmoothed
   assign step_w = cfg_r.substep_smoothing_on
      ? ((last_w && sub_r == SUB_LAST) ? 4'h0 : FINE_STEP)
      : ((sub_r == SUB_LAST && !last_w)
         ? COARSE_STEP : 4'h0);
   assign up_w = {1'b0, gain_r} + {6'h00, step_w};
   assign bad_w = dec_w ? (gain_r < {5'h00, step_w})
                  : (up_w > {1'b0, GAIN_MAX});
   assign start_u = to_units(cfg_r.start_gain);
   assign fixed_u = to_units(cfg_r.coarse)
                    + {6'h00, cfg_r.fractional_gain_offset};
   assign hold_load = 14'(cfg_r.hold * HOLD_MULT);
   assign go = (pin_go || soft_go_r) && !cfg_r.fixed_level_select;
   assign ret_dn = (gain_r - start_u > 9'h008)
                   ? gain_r - 9'h008 : start_u;
   assign ret_up = (start_u - gain_r > 9'h008)
                   ? gain_r + 9'h008 : start_u;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_q_r <= ST_IDLE;
         gain_r <= '0;
         idx_r <= '0;
         sub_r <= '0;
         dwell_r <= '0;
         hold_r <= '0;
      end else if (samp_en_r) begin
         if (go) begin
            eng_q_r <= ST_RAMP;
            gain_r <= start_u;
            idx_r <= cfg_r.start_idx;
            sub_r <= '0;
            dwell_r <= '0;
         end else if (cfg_r.fixed_level_select) begin
            eng_q_r <= ST_IDLE;
         end else begin
            unique case (eng_q_r)
               ST_IDLE: eng_q_r <= ST_IDLE;
               ST_RAMP: begin
                  if (!sub_end) dwell_r <= dwell_r + 8'h01;
                  else if (bad_w) begin
                     eng_q_r <= ST_HOLD;
                     hold_r <= hold_load;
                  end else begin
                     dwell_r <= '0;
                     sub_r <= sub_r + 3'h1;
                     gain_r <= dec_w ? gain_r - {5'h00, step_w}
                               : up_w[8:0];
                     if (sub_r == SUB_LAST) begin
                        if (last_w) begin
                           eng_q_r <= ST_HOLD;
                           hold_r <= hold_load;
                        end else idx_r <= idx_r + 8'h01;
                     end
                  end
               end
               ST_HOLD: begin
                  if (hold_r == 14'h0000) eng_q_r <= ST_RETURN;
                  else hold_r <= hold_r - 14'h0001;
               end
               ST_RETURN: begin
                  if (gain_r > start_u) gain_r <= ret_dn;
                  else if (gain_r < start_u) gain_r <= ret_up;
                  else if (cfg_r.soft_sync) begin
                     eng_q_r <= ST_RAMP;
                     idx_r <= cfg_r.start_idx;
                     sub_r <= '0;
                     dwell_r <= '0;
                  end else eng_q_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Switched gain only moves at the sampling instant
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gain_code <= '0;
         curve_active <= 1'b0;
      end else if (samp_en_r) begin
         gain_code <= cfg_r.fixed_level_select
                      ? fixed_u : gain_r;
         curve_active <= eng_q_r != ST_IDLE;
      end
   end

endmodule : vga_gain_time_sequencer

// ==== vga_tgs_host.sv ====
// Purpose: Host model driving serial frames and the sync pin.
// Assumes: Serial clock phases of four ref_clk periods each.
// Notes: A released data line shows the inverse of its last bit.
`timescale 1ns/1ps
module vga_tgs_host (
   input wire logic ref_clk,
   input wire logic ser_dout,
   output logic ser_clk,
   output logic ser_en_n,
   output logic ser_data,
   output logic sync_in
);
   initial begin
      ser_clk = 1'b0;
      ser_en_n = 1'b1;
      ser_data = 1'b0;
      sync_in = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick
   // Settings go in before any sync is raised
   task automatic frame(input logic [7:0] a, input logic [15:0] d,
                        output logic [15:0] q);
      logic [23:0] w;
      w = {a, d};
      tick(1);
      ser_en_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         ser_data = w[i];
         tick(4);
         ser_clk = 1'b1;
         tick(4);
         q = {q[14:0], ser_dout};
         ser_clk = 1'b0;
      end
      tick(4);
      ser_en_n = 1'b1;
      ser_data = ~ser_data;
      tick(8);
   endtask : frame
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] q;
      frame(a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      logic [15:0] z;
      frame(8'h00, 16'h0006, z);
      frame(a, 16'h0000, q);
      frame(8'h00, 16'h0004, z);
   endtask : rd
   // Launched just after a ref_clk edge, held two samples
   task automatic pulse();
      sync_in = 1'b1;
      tick(4);
      sync_in = 1'b0;
      tick(4);
   endtask : pulse
endmodule : vga_tgs_host

// ==== vga_gain_time_sequencer_sva.sv ====
// Purpose: Port-level checks of the gain sequencer.
// Assumes: One ref_clk domain, resetn active low.
// Notes: Helper counters judge steps only inside settled runs.
`timescale 1ns/1ps
module vga_gain_time_sequencer_sva
   import vga_tgs_pkg::*;
#(
   parameter int HOLD_MULT = HOLD_PER_CODE
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic sync_in,
   input wire logic ser_clk,
   input wire logic ser_en_n,
   input wire logic ser_data,
   input wire logic ser_dout,
   input wire logic [8:0] gain_code,
   input wire logic curve_active
);
   logic [3:0] act_r;
   logic [3:0] act_nxt;
   logic [4:0] quiet_r;
   logic [4:0] quiet_nxt;
   logic busy;
   // The start load may jump, so steps count only after it
   assign busy = act_r > 4'h3;
   assign act_nxt = curve_active ? act_r + 4'(act_r != 4'hF) : 4'h0;
   assign quiet_nxt = (!ser_en_n || sync_in) ? 5'h00
                      : quiet_r + 5'(quiet_r != 5'h1F);
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         act_r <= 4'h0;
         quiet_r <= 5'h00;
      end else begin
         act_r <= act_nxt;
         quiet_r <= quiet_nxt;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   a_gain_in_range: assert property (gain_code <= GAIN_MAX)
      else $error("gain above range");
   a_gain_on_sample: assert property (
      $changed(gain_code) |=> $stable(gain_code))
      else $error("gain changed off the sample edge");
   a_reset_quiet: assert property (
      $rose(resetn) |-> (gain_code == 9'h000 && !curve_active)
      ##1 gain_code == 9'h000)
      else $error("outputs moved at reset release");
   a_ramp_up_step: assert property (
      busy && gain_code > $past(gain_code)
      |-> gain_code - $past(gain_code) <= 9'h008)
      else $error("rising step above 1 dB");
   a_ret_down_step: assert property (
      busy && gain_code < $past(gain_code)
      |-> $past(gain_code) - gain_code <= 9'h008)
      else $error("falling step above 1 dB");
   a_active_min: assert property (
      $rose(curve_active) |-> curve_active [*8])
      else $error("run ended too soon");
   a_fall_steady: assert property (
      $fell(curve_active) && quiet_r > 5'h0F
      |=> $stable(gain_code) [*3])
      else $error("gain moved after run end");
   a_idle_gain_steady: assert property (
      !curve_active && $past(!curve_active) && $changed(gain_code)
      |-> quiet_r < 5'h10)
      else $error("idle gain moved without cause");
   c_run_start: cover property ($rose(curve_active));
   c_run_end: cover property ($fell(curve_active));
   c_gain_top: cover property (gain_code == GAIN_MAX);
endmodule : vga_gain_time_sequencer_sva
bind vga_gain_time_sequencer vga_gain_time_sequencer_sva #(
   .HOLD_MULT(HOLD_MULT)
) chk_u (
   .ref_clk(ref_clk), .resetn(resetn), .sync_in(sync_in),
   .ser_clk(ser_clk), .ser_en_n(ser_en_n), .ser_data(ser_data),
   .ser_dout(ser_dout), .gain_code(gain_code),
   .curve_active(curve_active)
);

// ==== vga_gain_time_sequencer_bench.sv ====
// Purpose: Self-checking bench of the gain time sequencer.
// Assumes: Short hold multiplier; host model drives serial and sync.
// Notes: Gain traces are compared as lists of distinct values.
`timescale 1ns/1ps
module vga_gain_time_sequencer_bench;
   import vga_tgs_pkg::*;
`define CMP(n, e, g) begin checks++; if ((g) !== (e)) begin \
   fails++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
   logic ref_clk, resetn, sync_in, ser_clk, ser_en_n, ser_data;
   logic ser_dout, curve_active;
   logic [8:0] gain_code;
   logic [15:0] rv;
   logic [8:0] got_q[$];
   int exp_q[$];
   int len_q[$];
   int fails = 0;
   int checks = 0;
   int cyc = 0;
   int f;
   int cv[4] = '{0, 36, 63, 5};
   vga_gain_time_sequencer #(.HOLD_MULT(2)) DUT (
      .ref_clk(ref_clk), .resetn(resetn), .sync_in(sync_in),
      .ser_clk(ser_clk), .ser_en_n(ser_en_n), .ser_data(ser_data),
      .ser_dout(ser_dout), .gain_code(gain_code),
      .curve_active(curve_active)
   );
   vga_tgs_host host (
      .ref_clk(ref_clk), .ser_dout(ser_dout), .ser_clk(ser_clk),
      .ser_en_n(ser_en_n), .ser_data(ser_data), .sync_in(sync_in)
   );
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic wrap_up();
      if (fails == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 50000) begin
         fails++;
         wrap_up();
      end
   end
   task automatic wait_idle();
      for (int i = 0; i < 3000 && curve_active !== 1'b0; i++) host.tick(1);
      `CMP("idle", 1'b0, curve_active)
   endtask : wait_idle
   // Last entry stops one sub-step short, or frozen when unsmoothed
   task automatic model(input int s, input int dir[$], input bit sm);
      int g;
      int n;
      g = s;
      exp_q = {s};
      foreach (dir[i]) begin
         n = (i == dir.size() - 1) ? (sm ? 7 : 0) : (sm ? 8 : 1);
         repeat (n) begin
            g += dir[i] * (sm ? 1 : 8);
            exp_q.push_back(g);
         end
      end
      while (g > s) begin
         g = (g - 8 < s) ? s : g - 8;
         exp_q.push_back(g);
      end
   endtask : model
   task automatic capture(input int n);
      got_q = {gain_code};
      len_q = {0};
      repeat (n) begin
         host.tick(1);
         if (gain_code !== got_q[$]) begin
            got_q.push_back(gain_code);
            len_q.push_back(0);
         end
         len_q[len_q.size() - 1]++;
      end
   endtask : capture
   task automatic run(input int si, input int sg, input bit sm,
                      input bit uni, input int dir[$]);
      int c;
      c = uni ? 1 : $urandom_range(3);
      foreach (dir[i]) begin
         if (!uni) host.wr(8'(si + i), 16'({dir[i] < 0, 8'(c)}));
      end
      host.wr(A_START_IDX, 16'(si));
      host.wr(A_STOP_IDX, 16'(si + dir.size() - 1));
      host.wr(A_START_GAIN, {8'h00, sm, 1'b0, 6'(sg)});
      host.wr(A_HOLD, 16'h0001);
      host.wr(A_SLOPE, 16'h0001);
      host.wr(A_MODE, uni ? 16'h0010 : 16'h0000);
      host.pulse();
      wait_idle();
      model(sg * 8, dir, sm);
      fork
         capture(800);
         host.pulse();
      join
      `CMP("steps", exp_q.size(), got_q.size())
      foreach (exp_q[i]) `CMP("trace", exp_q[i], got_q[i])
      `CMP("dwell", (sm ? 2 : 16) * (c > 0 ? c : 1), len_q[1])
   endtask : run
   initial begin
      resetn = 1'b0;
      void'($urandom(32'hB208));
      repeat (16) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      host.tick(8);
      host.wr(A_CTRL, 16'h0004);
      host.rd(A_MODE, rv);
      `CMP("mode_reset", 16'h0000, rv)
      run(1, 5, 1'b1, 1'b0, {1, -1, 1});
      run(146, 5, 1'b0, 1'b0, {1, -1, 1});
      run(0, 2, 1'b1, 1'b1, {1, 1, 1});
      run(0, 2, 1'b0, 1'b1, {1, 1, 1});
      model(16, {1, 1, 1}, 1'b0);
      exp_q.pop_back();
      exp_q = {exp_q, exp_q, 16};
      fork
         host.wr(A_MODE, 16'h0030);
         begin
            host.tick(180);
            capture(260);
         end
      join
      foreach (exp_q[i]) `CMP("soft", exp_q[i], got_q[i])
      host.wr(A_MODE, 16'h0010);
      wait_idle();
      cv[3] = $urandom_range(63);
      foreach (cv[i]) begin
         f = $urandom_range(7);
         host.wr(A_COARSE, 16'(cv[i]));
         host.wr(A_MODE, 16'(8 + f));
         `CMP("fixed", (cv[i] > 36 ? 36 : cv[i]) * 8 + f, gain_code)
         host.rd(A_MODE, rv);
         `CMP("mode_rd", 16'(8 + f), rv)
      end
      host.pulse();
      `CMP("no_run", 1'b0, curve_active)
      // Reset of random length in fixed mode, engine idle, must clear settings and the gain output
      resetn = 1'b0;
      host.tick(2 + $urandom_range(3));
      `CMP("rst_gain", 9'h000, gain_code)
      resetn = 1'b1;
      host.tick(8);
      host.rd(A_MODE, rv);
      `CMP("mode_rst2", 16'h0000, rv)
      wrap_up();
   end
endmodule : vga_gain_time_sequencer_bench
